//--- nvc_pkg.sv
// package: register map, control bit positions, unlock keys and timing of the memory access control block
package nvc_pkg;
	// register indices on the special function register port
	localparam logic [3:0] NVC_REG_ADDR_LOW  = 4'h0;
	localparam logic [3:0] NVC_REG_ADDR_HIGH = 4'h1;
	localparam logic [3:0] NVC_REG_DATA      = 4'h2;
	localparam logic [3:0] NVC_REG_CONTROL   = 4'h3;
	localparam logic [3:0] NVC_REG_UNLOCK    = 4'h4;
	localparam logic [3:0] NVC_REG_IRQ_FLAGS = 4'h5;
	localparam logic [3:0] NVC_REG_TBL_UPPER = 4'h6;
	localparam logic [3:0] NVC_REG_TBL_HIGH  = 4'h7;
	localparam logic [3:0] NVC_REG_TBL_LOW   = 4'h8;

	// control register bit positions
	localparam int NVC_BIT_RD    = 0;
	localparam int NVC_BIT_WR    = 1;
	localparam int NVC_BIT_WRITE_ENABLE_BIT  = 2;
	localparam int NVC_BIT_WRITE_ERROR_FLAG = 3;
	localparam int NVC_BIT_FREE  = 4;
	localparam int NVC_BIT_CONFIG_SPACE_SELECT  = 6;
	localparam int NVC_BIT_PGD   = 7;
	// write-done flag position in peripheral irq flags 2
	localparam int NVC_BIT_DONE  = 4;

	localparam logic [7:0] NVC_KEY_FIRST  = 8'h55;
	localparam logic [7:0] NVC_KEY_SECOND = 8'hAA;
	localparam logic [7:0] NVC_RESET_BYTE = 8'h00;
	localparam logic [7:0] NVC_IRQ2_MASK  = 8'hFE;

	// timing
	localparam int NVC_CLK_MHZ        = 200;
	localparam int NVC_WRITE_TIME_US  = 4000;
	localparam int NVC_WRITE_CYCLES   = NVC_WRITE_TIME_US * NVC_CLK_MHZ;
	localparam int NVC_PWRT_TIME_US   = 65000;
	localparam int NVC_PWRT_CYCLES    = NVC_PWRT_TIME_US * NVC_CLK_MHZ;

	typedef enum logic [1:0] {
		NVC_UL_IDLE  = 2'b00,
		NVC_UL_FIRST = 2'b01,
		NVC_UL_ARMED = 2'b11
	} nvc_unlock_t;

	typedef enum logic [1:0] {
		NVC_SP_DATA   = 2'b00,
		NVC_SP_FLASH  = 2'b01,
		NVC_SP_CONFIG = 2'b11
	} nvc_space_t;

	typedef struct packed {
		logic [3:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} nvc_sfr_req_t;

	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] data;
		logic       erase_row;
		nvc_space_t space;
	} nvc_mem_cmd_t;
endpackage : nvc_pkg

//--- nvc_ctrl.sv
// module: control of data memory reads and writes and program flash erase/write through registers
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1: reset during write sets error flag
// R2: flash writes need same unlock sequence
// R3: data register holds byte, address pair selects
// R4: low eight bits plus two high bits
// R5: byte write is self-timed erase then program
// R6: select bit picks flash or data memory
// R7: config select overrides memory select
// R8: writes only with enable; enable cleared at power-up
// R9: error set on strobe, cleared on completion
// R10: improper write attempt also sets error
// R11: write strobe software-set only, hardware-cleared
// R12: write strobe starts cycle per selected space
// R13: completion sets sticky done flag
// R14: read strobe ignored for flash or config
// R15: data read completes in one cycle
// R16: data register keeps last read byte
// R17: unlock port has no storage, reads zero
// R18: row erase bit erases, cleared at completion
// R19: error keeps space select bits unchanged
// R20: unimplemented bits read zero
// R21: 55h then AAh then strobe starts write
// R22: enable and strobe together start nothing
// R23: registers locked while write runs; enable kept
// R24: data writes blocked during power-up timer; code checks prior space_r, so a strobe that switches to data still starts
// R25: write duration is parameter count
// R26: error flag survives master-clear and watchdog
module nvc_ctrl import nvc_pkg::*; #(
	parameter int WRITE_CYCLES = NVC_WRITE_CYCLES,
	parameter int PWRT_CYCLES  = NVC_PWRT_CYCLES
) (
	input  wire logic         sys_clk,
	input  wire logic         reset,
	input  wire logic         por_reset,
	input  wire nvc_sfr_req_t sfr_req,
	output logic [7:0]        sfr_rdata,
	output nvc_mem_cmd_t      mem_cmd,
	output logic              mem_write_start,
	output logic              mem_read_start,
	input  wire logic [7:0]   mem_rdata,
	output logic              write_busy,
	output logic              done_flag
);
	// reset is the master-clear/watchdog reset; por_reset is power-on and clears everything
	localparam int WC_W = $clog2(WRITE_CYCLES + 1);
	localparam int PC_W = $clog2(PWRT_CYCLES + 1);

	logic [7:0]  addr_low_r, data_r, irq2_r, tbl_up_r, tbl_hi_r, tbl_lo_r, rdata_r;
	logic [1:0]  addr_high_r;
	logic        pgd_r, config_space_select_r, free_r, write_enable_bit_r, wr_r, rd_r, write_error_flag_r;
	nvc_unlock_t unlock_r, unlock_nxt;
	logic [WC_W-1:0] wcnt_r;
	logic [PC_W-1:0] pcnt_r;
	logic        pwrt_done_r, mem_ws_r, mem_rs_r;

	wire wr_sel   = sfr_req.wr;
	wire [7:0] wd = sfr_req.wdata;
	wire we_ctl   = wr_sel && sfr_req.addr == NVC_REG_CONTROL;
	wire we_alow  = wr_sel && sfr_req.addr == NVC_REG_ADDR_LOW;
	wire we_ahigh = wr_sel && sfr_req.addr == NVC_REG_ADDR_HIGH;
	wire we_data  = wr_sel && sfr_req.addr == NVC_REG_DATA;
	wire we_ul    = wr_sel && sfr_req.addr == NVC_REG_UNLOCK;
	wire we_irq   = wr_sel && sfr_req.addr == NVC_REG_IRQ_FLAGS;
	wire locked   = wr_r; // [R23]

	// space is decoded from the written selects and kept in a flop so the output stays glitch-free
	nvc_space_t space_r, space_nxt;
	assign space_nxt = wd[NVC_BIT_CONFIG_SPACE_SELECT] ? NVC_SP_CONFIG : (wd[NVC_BIT_PGD] ? NVC_SP_FLASH : NVC_SP_DATA); // [R6] [R7]

	// strobe only counts if enable was already set before this write [R22] [R8]
	wire wr_req     = we_ctl && !locked && wd[NVC_BIT_WR] && write_enable_bit_r;
	wire unlock_ok  = unlock_r == NVC_UL_ARMED; // [R21] [R2]
	wire data_block = (space_r == NVC_SP_DATA) && !pwrt_done_r; // [R24]
	wire wr_go      = wr_req && unlock_ok && !data_block;
	wire wr_bad     = we_ctl && !locked && wd[NVC_BIT_WR] && !wr_go; // [R10]
	// reads are refused for flash and config, which are read through table reads
	wire rd_go      = we_ctl && !locked && wd[NVC_BIT_RD] && !wd[NVC_BIT_CONFIG_SPACE_SELECT] &&
	                  !wd[NVC_BIT_PGD] && !rd_r; // [R14]
	wire wr_finish  = wr_r && wcnt_r == WC_W'(1); // [R25]

	// any write to a register other than the unlock port, the armed strobe included, breaks the sequence
	always_comb begin
		unlock_nxt = unlock_r;
		if (we_ul) begin
			if (wd == NVC_KEY_FIRST)
				unlock_nxt = NVC_UL_FIRST;
			else if (wd == NVC_KEY_SECOND && unlock_r == NVC_UL_FIRST)
				unlock_nxt = NVC_UL_ARMED;
			else
				unlock_nxt = NVC_UL_IDLE;
		end else if (wr_sel && unlock_r != NVC_UL_IDLE) begin
			unlock_nxt = NVC_UL_IDLE; // [R21]
		end
	end

	// power-up timer: only power-on restarts it
	always_ff @(posedge sys_clk or posedge por_reset) begin
		if (por_reset) begin
			pcnt_r      <= '0;
			pwrt_done_r <= 1'b0;
		end else if (!pwrt_done_r) begin
			pcnt_r      <= pcnt_r + PC_W'(1);
			pwrt_done_r <= pcnt_r == PC_W'(PWRT_CYCLES - 1); // [R24]
		end
	end

	// error flag lives on the power-on reset only so it is still visible after master-clear [R26]
	always_ff @(posedge sys_clk or posedge por_reset) begin
		if (por_reset)
			write_error_flag_r <= 1'b0;
		else if (reset && wr_r)
			write_error_flag_r <= 1'b1; // [R1]
		else if (wr_go || wr_bad)
			write_error_flag_r <= 1'b1; // [R9] [R10]
		else if (wr_finish)
			write_error_flag_r <= 1'b0; // [R9]
	end

	// space selects are left unknown-free and untouched by the master-clear/watchdog reset that aborts a write; only por_reset clears them [R19]
	always_ff @(posedge sys_clk or posedge por_reset) begin
		if (por_reset) begin
			pgd_r   <= 1'b0;
			config_space_select_r  <= 1'b0;
			space_r <= NVC_SP_DATA;
		end else if (we_ctl && !locked && !reset) begin
			pgd_r   <= wd[NVC_BIT_PGD];
			config_space_select_r  <= wd[NVC_BIT_CONFIG_SPACE_SELECT];
			space_r <= space_nxt; // [R6] [R7]
		end
	end

	always_ff @(posedge sys_clk or posedge reset or posedge por_reset) begin
		if (reset || por_reset) begin
			write_enable_bit_r   <= 1'b0; // [R8]
			free_r   <= 1'b0;
			wr_r     <= 1'b0;
			rd_r     <= 1'b0;
			unlock_r <= NVC_UL_IDLE;
			wcnt_r   <= '0;
		end else begin
			unlock_r <= unlock_nxt;
			rd_r     <= rd_go; // [R15]
			if (we_ctl && !locked) begin
				write_enable_bit_r <= wd[NVC_BIT_WRITE_ENABLE_BIT]; // [R23] write completion never clears it; only reset and por_reset do
				free_r <= wd[NVC_BIT_FREE];
			end else if (wr_finish) begin
				free_r <= 1'b0; // [R18]
			end
			if (wr_go) begin
				wr_r   <= 1'b1; // [R11] [R12]
				wcnt_r <= WC_W'(WRITE_CYCLES); // [R5]
			end else if (wr_finish) begin
				wr_r   <= 1'b0; // [R11]
				wcnt_r <= '0;
			end else if (wr_r) begin
				wcnt_r <= wcnt_r - WC_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset or posedge por_reset) begin
		if (reset || por_reset) begin
			addr_low_r  <= NVC_RESET_BYTE;
			addr_high_r <= 2'h0;
			data_r      <= NVC_RESET_BYTE;
			irq2_r      <= NVC_RESET_BYTE;
			tbl_up_r    <= NVC_RESET_BYTE;
			tbl_hi_r    <= NVC_RESET_BYTE;
			tbl_lo_r    <= NVC_RESET_BYTE;
		end else begin
			if (we_alow && !locked)
				addr_low_r <= wd; // [R4]
			if (we_ahigh && !locked)
				addr_high_r <= wd[1:0]; // [R4]
			if (rd_r)
				data_r <= mem_rdata; // [R15] [R16]
			else if (we_data && !locked)
				data_r <= wd; // [R3]
			if (we_irq)
				irq2_r <= wd & NVC_IRQ2_MASK;
			if (wr_finish)
				irq2_r[NVC_BIT_DONE] <= 1'b1; // [R13] set wins over a same-cycle clear
			if (wr_sel && sfr_req.addr == NVC_REG_TBL_UPPER)
				tbl_up_r <= {3'h0, wd[4:0]};
			if (wr_sel && sfr_req.addr == NVC_REG_TBL_HIGH)
				tbl_hi_r <= wd;
			if (wr_sel && sfr_req.addr == NVC_REG_TBL_LOW)
				tbl_lo_r <= wd;
		end
	end

	logic [7:0] ctl_view, rd_mux;
	assign ctl_view = {pgd_r, config_space_select_r, 1'b0, free_r, write_error_flag_r, write_enable_bit_r, wr_r, rd_r}; // [R20]
	always_comb begin
		unique case (sfr_req.addr)
			NVC_REG_ADDR_LOW:  rd_mux = addr_low_r;
			NVC_REG_ADDR_HIGH: rd_mux = {6'h00, addr_high_r}; // [R20]
			NVC_REG_DATA:      rd_mux = data_r;
			NVC_REG_CONTROL:   rd_mux = ctl_view;
			NVC_REG_IRQ_FLAGS: rd_mux = irq2_r;
			NVC_REG_TBL_UPPER: rd_mux = tbl_up_r;
			NVC_REG_TBL_HIGH:  rd_mux = tbl_hi_r;
			NVC_REG_TBL_LOW:   rd_mux = tbl_lo_r;
			default:           rd_mux = NVC_RESET_BYTE; // [R17] unlock port and holes read zero
		endcase
	end

	// read data registered one cycle after the request
	always_ff @(posedge sys_clk or posedge por_reset) begin
		if (por_reset) begin
			rdata_r  <= NVC_RESET_BYTE;
			mem_ws_r <= 1'b0;
			mem_rs_r <= 1'b0;
		end else begin
			rdata_r  <= sfr_req.rd ? rd_mux : NVC_RESET_BYTE;
			mem_ws_r <= wr_go && !reset;
			mem_rs_r <= rd_go && !reset;
		end
	end

	assign sfr_rdata       = rdata_r;
	assign mem_cmd         = '{addr: {addr_high_r, addr_low_r}, data: data_r, erase_row: free_r, space: space_r};
	assign mem_write_start = mem_ws_r;
	assign mem_read_start  = mem_rs_r;
	assign write_busy      = wr_r;
	assign done_flag       = irq2_r[NVC_BIT_DONE];
endmodule : nvc_ctrl

`default_nettype wire

//--- nvc_ctrl_monitor.sv
// checker: port-level assertions for the memory access control block
`timescale 1ns/1ps
`default_nettype none
module nvc_ctrl_monitor import nvc_pkg::*; (
	input wire logic         sys_clk,
	input wire logic         reset,
	input wire logic         por_reset,
	input wire nvc_sfr_req_t sfr_req,
	input wire logic [7:0]   sfr_rdata,
	input wire nvc_mem_cmd_t mem_cmd,
	input wire logic         mem_write_start,
	input wire logic         mem_read_start,
	input wire logic [7:0]   mem_rdata,
	input wire logic         write_busy,
	input wire logic         done_flag
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset || por_reset);
	sequence s_ctl_rd;
		sfr_req.wr && sfr_req.addr == NVC_REG_CONTROL && sfr_req.wdata[0];
	endsequence
	sequence s_start;
		mem_write_start && $rose(write_busy);
	endsequence
	property p_start; mem_write_start |-> s_start; endproperty
	a_start: assert property (p_start) else $error("write start without busy rising");
	property p_hold; s_start |=> write_busy [*8]; endproperty
	a_hold: assert property (p_hold) else $error("busy dropped early");
	property p_done; $fell(write_busy) |-> done_flag && $stable(mem_cmd.space); endproperty
	a_done: assert property (p_done) else $error("completion without done flag");
	property p_lock; write_busy && $past(write_busy) |-> $stable(mem_cmd.addr) && $stable(mem_cmd.data); endproperty
	a_lock: assert property (p_lock) else $error("address or data moved while busy");
	property p_rd; s_ctl_rd ##0 (sfr_req.wdata[7:6] == 2'b00 && !write_busy && !mem_read_start) |=> mem_read_start;
	endproperty
	a_rd: assert property (p_rd) else $error("data read not started");
	property p_rd_block; s_ctl_rd ##0 (sfr_req.wdata[7:6] != 2'b00) |=> !mem_read_start; endproperty
	a_rd_block: assert property (p_rd_block) else $error("read started in flash or config");
	property p_unlock_rd; sfr_req.rd && sfr_req.addr == NVC_REG_UNLOCK |=> sfr_rdata == 8'h00; endproperty
	a_unlock_rd: assert property (p_unlock_rd) else $error("unlock port read not zero");
	property p_done_hold; done_flag && !(sfr_req.wr && sfr_req.addr == NVC_REG_IRQ_FLAGS) |=> done_flag; endproperty
	a_done_hold: assert property (p_done_hold) else $error("done flag lost");
endmodule : nvc_ctrl_monitor
bind nvc_ctrl nvc_ctrl_monitor i_mon (.sys_clk(sys_clk), .reset(reset), .por_reset(por_reset),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .mem_cmd(mem_cmd), .mem_write_start(mem_write_start),
	.mem_read_start(mem_read_start), .mem_rdata(mem_rdata), .write_busy(write_busy), .done_flag(done_flag));
`default_nettype wire

//--- nvc_ctrl_bench.sv
// testbench: register-level checks of the memory access control block
`timescale 1ns/1ps
`default_nettype none
module nvc_ctrl_bench import nvc_pkg::*;;
	localparam int WC = 20;
	logic         sys_clk = 1'b0;
	logic         reset = 1'b1;
	logic         por_reset = 1'b1;
	nvc_sfr_req_t sfr_req = '0;
	logic [7:0]   sfr_rdata;
	nvc_mem_cmd_t mem_cmd;
	logic         mem_write_start;
	logic         mem_read_start;
	logic [7:0]   mem_rdata = 8'hA5;
	logic         write_busy;
	logic         done_flag;
	int           fails = 0;
	int           samples_checked = 0;
	int           cycles = 0;
	int           n;
	logic [7:0]   rv;
	nvc_ctrl #(.WRITE_CYCLES(WC), .PWRT_CYCLES(10)) i_dut (.sys_clk(sys_clk), .reset(reset),
		.por_reset(por_reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .mem_cmd(mem_cmd),
		.mem_write_start(mem_write_start), .mem_read_start(mem_read_start), .mem_rdata(mem_rdata),
		.write_busy(write_busy), .done_flag(done_flag));
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	// the whole run is about 150 cycles, so this only trips on a hang
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			fails = fails + 1;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge sys_clk);
		sfr_req <= '0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge sys_clk);
		sfr_req <= '0;
		#1 v = sfr_rdata;
	endtask : rd
	task automatic go(input logic [7:0] c);
		wr(NVC_REG_UNLOCK, NVC_KEY_FIRST);
		wr(NVC_REG_UNLOCK, NVC_KEY_SECOND);
		wr(NVC_REG_CONTROL, c);
		#1;
	endtask : go
	task automatic wait_done(output int k);
		#1 k = 0;
		while (write_busy === 1'b1 && k < 100) begin
			@(posedge sys_clk);
			#1 k++;
		end
	endtask : wait_done
	initial begin
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		por_reset <= 1'b0;
		rd(NVC_REG_CONTROL, rv);
		chk("ctl", 16'h0000, rv);
		rd(NVC_REG_UNLOCK, rv);
		chk("unlock", 16'h0000, rv);
		wr(NVC_REG_ADDR_HIGH, 8'hFF);
		rd(NVC_REG_ADDR_HIGH, rv);
		chk("addr_high", 16'h0003, rv);
		wr(NVC_REG_ADDR_LOW, 8'h5A);
		wr(NVC_REG_ADDR_HIGH, 8'h01);
		wr(NVC_REG_DATA, 8'hC3);
		#1;
		chk("addr", 16'h015A, mem_cmd.addr);
		chk("data", 16'h00C3, mem_cmd.data);
		go(8'h06);
		chk("busy", 16'h0000, write_busy);
		wr(NVC_REG_CONTROL, 8'h04);
		wr(NVC_REG_CONTROL, 8'h06);
		#1 chk("busy", 16'h0000, write_busy);
		rd(NVC_REG_CONTROL, rv);
		chk("ctl", 16'h000C, rv);
		go(8'h06);
		chk("start", 16'h0001, mem_write_start);
		rd(NVC_REG_CONTROL, rv);
		chk("ctl", 16'h000E, rv);
		wr(NVC_REG_ADDR_LOW, 8'h00);
		wait_done(n);
		chk("len", 16'(WC - 4), 16'(n));
		chk("addr", 16'h015A, mem_cmd.addr);
		chk("done", 16'h0001, done_flag);
		rd(NVC_REG_CONTROL, rv);
		chk("ctl", 16'h0004, rv);
		rd(NVC_REG_IRQ_FLAGS, rv);
		chk("irq", 16'h0010, rv);
		wr(NVC_REG_IRQ_FLAGS, 8'h00);
		#1 chk("done", 16'h0000, done_flag);
		wr(NVC_REG_CONTROL, 8'h01);
		#1 chk("rstart", 16'h0001, mem_read_start);
		rd(NVC_REG_DATA, rv);
		chk("rdata", 16'h00A5, rv);
		mem_rdata <= 8'h3C;
		wr(NVC_REG_CONTROL, 8'h81);
		#1 chk("rstart", 16'h0000, mem_read_start);
		rd(NVC_REG_DATA, rv);
		chk("rdata", 16'h00A5, rv);
		wr(NVC_REG_CONTROL, 8'h94);
		go(8'h96);
		chk("space", 16'(NVC_SP_FLASH), mem_cmd.space);
		chk("erase", 16'h0001, mem_cmd.erase_row);
		wait_done(n);
		chk("len", 16'(WC), 16'(n));
		chk("erase", 16'h0000, mem_cmd.erase_row);
		wr(NVC_REG_CONTROL, 8'hC4);
		#1;
		chk("space", 16'(NVC_SP_CONFIG), mem_cmd.space);
		wr(NVC_REG_CONTROL, 8'h84);
		go(8'h86);
		repeat (3) @(posedge sys_clk);
		reset <= 1'b1;
		@(posedge sys_clk);
		reset <= 1'b0;
		rd(NVC_REG_CONTROL, rv);
		chk("ctl", 16'h0088, rv);
		por_reset <= 1'b1;
		@(posedge sys_clk);
		por_reset <= 1'b0;
		wr(NVC_REG_CONTROL, 8'h04);
		go(8'h06);
		chk("busy", 16'h0000, write_busy);
		go(8'h06);
		chk("busy", 16'h0001, write_busy);
		wait_done(n);
		chk("len", 16'(WC), 16'(n));
		report_and_stop();
	end
endmodule : nvc_ctrl_bench
`default_nettype wire
